// ---- design/dv_addr_step.sv ----
// Next sector address in block or cylinder/head/sector form
module dv_addr_step #(
   parameter int HEADS = 16,
   parameter int SECTORS_PER_TRACK = 63
) (
   input wire logic lba_mode_i,
   input wire logic [7:0] sn_i,
   input wire logic [7:0] cl_i,
   input wire logic [7:0] ch_i,
   input wire logic [3:0] head_i,
   output logic [7:0] sn_o,
   output logic [7:0] cl_o,
   output logic [7:0] ch_o,
   output logic [3:0] head_o
);
   localparam logic [7:0] LAST_SECT = 8'(SECTORS_PER_TRACK);
   localparam logic [3:0] LAST_HEAD = 4'(HEADS - 1);
   logic [27:0] lba;
   logic [15:0] cyl;

   always_comb begin
      lba = {head_i, ch_i, cl_i, sn_i} + 28'h0000001;
      cyl = {ch_i, cl_i} + 16'h0001;
      sn_o = sn_i + 8'h01;
      cl_o = cl_i;
      ch_o = ch_i;
      head_o = head_i;
      if (lba_mode_i) begin
         {head_o, ch_o, cl_o, sn_o} = lba;
      end else if (sn_i >= LAST_SECT) begin
         sn_o = 8'h01;
         head_o = head_i + 4'h1;
         if (head_i >= LAST_HEAD) begin
            head_o = 4'h0;
            {ch_o, cl_o} = cyl;
         end
      end
   end
endmodule

// ---- design/dv_cmd_engine.sv ----
// Task-file command engine for DMA read, read-verify and transfer mode selection
`include "dv_defs.svh"
module dv_cmd_engine #(
   parameter int WORDS_PER_SECTOR = 256,
   parameter int HEADS = 16,
   parameter int SECTORS_PER_TRACK = 63,
   parameter logic DRIVE_ID = 1'b0
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [9:0] host_addr_i,
   input wire logic host_wr_i,
   input wire logic host_rd_i,
   input wire logic [7:0] host_wdata_i,
   output logic [7:0] host_rdata_o,
   output logic intrq_o,
   output logic dmarq_o,
   input wire logic dmack_i,
   output logic [15:0] dma_data_o,
   output dv_pkg::dv_dma_mode_t dma_mode_o,
   output logic med_start_o,
   output logic med_verify_o,
   output logic med_retry_o,
   output logic med_lba_mode_o,
   output logic [27:0] med_addr_o,
   input wire logic [15:0] med_data_i,
   input wire logic med_valid_i,
   output logic med_ready_o,
   input wire logic med_done_i,
   input wire logic med_err_i,
   input wire logic med_corr_i
);
   logic rst_n;
   dv_rst_sync u_rst (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .rst_n_o(rst_n)
   );

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   dv_pkg::dv_state_t state_reg, state_next;
   dv_pkg::dv_dma_mode_t mode_reg, mode_next;
   logic [7:0] feat_reg, feat_next, fault_reg, fault_next;
   logic [7:0] sc_reg, sc_next, sn_reg, sn_next;
   logic [7:0] cl_reg, cl_next, ch_reg, ch_next, dh_reg, dh_next;
   logic [7:0] rdata_reg, rdata_next;
   logic bsy_reg, bsy_next, drq_reg, drq_next;
   logic corr_reg, corr_next, errb_reg, errb_next;
   logic corr_acc_reg, corr_acc_next;
   logic intrq_reg, intrq_next, start_reg, start_next;
   logic verify_reg, verify_next, retry_reg, retry_next;
   logic [8:0] left_reg, left_next;
   logic word_valid_reg, word_valid_next;
   logic [15:0] word_reg, word_next;

   logic [7:0] sn_step, cl_step, ch_step;
   logic [3:0] head_step;
   logic take, load, accept;
   dv_pkg::dv_kind_t kind;

   dv_addr_step #(
      .HEADS(HEADS),
      .SECTORS_PER_TRACK(SECTORS_PER_TRACK)
   ) u_step (
      .lba_mode_i(dh_reg[`DV_DH_LBA]),
      .sn_i(sn_reg),
      .cl_i(cl_reg),
      .ch_i(ch_reg),
      .head_i(dh_reg[3:0]),
      .sn_o(sn_step),
      .cl_o(cl_step),
      .ch_o(ch_step),
      .head_o(head_step)
   );

   function automatic dv_pkg::dv_kind_t decode(input logic [7:0] code);
      case (code)
         `DV_CMD_RDMA, `DV_CMD_RDMA_NR: decode = dv_pkg::DV_K_READ;
         `DV_CMD_VERIFY, `DV_CMD_VERIFY_NR: decode = dv_pkg::DV_K_VERIFY;
         `DV_CMD_SETF: decode = dv_pkg::DV_K_SETF;
         default: decode = dv_pkg::DV_K_BAD;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // Next values
   // -----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      mode_next = mode_reg;
      feat_next = feat_reg;
      fault_next = fault_reg;
      sc_next = sc_reg;
      sn_next = sn_reg;
      cl_next = cl_reg;
      ch_next = ch_reg;
      dh_next = dh_reg;
      bsy_next = bsy_reg;
      drq_next = drq_reg;
      corr_next = corr_reg;
      errb_next = errb_reg;
      corr_acc_next = corr_acc_reg;
      intrq_next = intrq_reg;
      start_next = 1'b0;
      verify_next = verify_reg;
      retry_next = retry_reg;
      left_next = left_reg;
      word_valid_next = word_valid_reg;
      word_next = word_reg;
      rdata_next = rdata_reg;
      kind = decode(host_wdata_i);

      // Data path: one word stage, request up only while it holds data
      if (take) begin
         word_valid_next = 1'b0;
      end
      if (load) begin
         word_valid_next = 1'b1;
         word_next = med_data_i;
      end

      // Host reads: status read acknowledges the interrupt
      if (host_rd_i) begin
         case (host_addr_i)
            `DV_OFF_FEAT: rdata_next = fault_reg;
            `DV_OFF_SC: rdata_next = sc_reg;
            `DV_OFF_SN: rdata_next = sn_reg;
            `DV_OFF_CL: rdata_next = cl_reg;
            `DV_OFF_CH: rdata_next = ch_reg;
            `DV_OFF_DH: rdata_next = dh_reg;
            `DV_OFF_CMD: begin
               rdata_next = `DV_BYTE_ZERO;
               rdata_next[`DV_ST_BSY] = bsy_reg;
               rdata_next[`DV_ST_DRDY] = !bsy_reg;
               rdata_next[`DV_ST_DSC] = 1'b1;
               rdata_next[`DV_ST_DRQ] = drq_reg;
               rdata_next[`DV_ST_CORR] = corr_reg;
               rdata_next[`DV_ST_ERR] = errb_reg;
               intrq_next = 1'b0;
            end
            default: rdata_next = `DV_BYTE_ZERO;
         endcase
      end

      // Host writes are dropped while busy
      accept = 1'b0;
      if (host_wr_i && !bsy_reg && state_reg == dv_pkg::DV_IDLE) begin
         case (host_addr_i)
            `DV_OFF_FEAT: feat_next = host_wdata_i;
            `DV_OFF_SC: sc_next = host_wdata_i;
            `DV_OFF_SN: sn_next = host_wdata_i;
            `DV_OFF_CL: cl_next = host_wdata_i;
            `DV_OFF_CH: ch_next = host_wdata_i;
            `DV_OFF_DH: dh_next = host_wdata_i;
            `DV_OFF_CMD: accept = dh_reg[`DV_DH_DRV] == DRIVE_ID;
            default: ;
         endcase
      end

      case (state_reg)
         dv_pkg::DV_IDLE: begin
            if (accept) begin
               bsy_next = 1'b1;
               intrq_next = 1'b0;
               errb_next = 1'b0;
               corr_next = 1'b0;
               corr_acc_next = 1'b0;
               fault_next = `DV_BYTE_ZERO;
               retry_next = !host_wdata_i[`DV_CMD_NORETRY];
               verify_next = kind == dv_pkg::DV_K_VERIFY;
               left_next = (sc_reg == `DV_BYTE_ZERO) ? `DV_SC_FULL : {1'b0, sc_reg};
               state_next = dv_pkg::DV_POST;
               case (kind)
                  dv_pkg::DV_K_READ, dv_pkg::DV_K_VERIFY: begin
                     state_next = dv_pkg::DV_START;
                  end
                  dv_pkg::DV_K_SETF: begin
                     if (feat_reg == `DV_FEAT_XFER_MODE && sc_reg == `DV_MODE_SW2) begin
                        mode_next = dv_pkg::DV_DMA_SW2;
                     end else if (feat_reg == `DV_FEAT_XFER_MODE &&
                                  sc_reg == `DV_MODE_MW2) begin
                        mode_next = dv_pkg::DV_DMA_MW2;
                     end else if (feat_reg == `DV_FEAT_XFER_MODE &&
                                  sc_reg == `DV_MODE_UDMA2) begin
                        mode_next = dv_pkg::DV_DMA_UDMA2;
                     end else begin
                        errb_next = 1'b1;
                        fault_next[`DV_ER_ABRT] = 1'b1;
                     end
                  end
                  default: begin
                     errb_next = 1'b1;
                     fault_next[`DV_ER_ABRT] = 1'b1;
                  end
               endcase
            end
         end
         dv_pkg::DV_START: begin
            start_next = 1'b1;
            drq_next = !verify_reg;
            state_next = dv_pkg::DV_XFER;
         end
         dv_pkg::DV_XFER: begin
            if (med_done_i) begin
               if (med_err_i) begin
                  // Address stays on the failing sector
                  errb_next = 1'b1;
                  fault_next[`DV_ER_UNC] = 1'b1;
                  sc_next = left_reg[7:0];
                  state_next = dv_pkg::DV_DRAIN;
               end else begin
                  corr_acc_next = corr_acc_reg || med_corr_i;
                  left_next = left_reg - 9'h001;
                  if (left_reg == 9'h001) begin
                     sc_next = `DV_BYTE_ZERO;
                     state_next = dv_pkg::DV_DRAIN;
                  end else begin
                     sn_next = sn_step;
                     cl_next = cl_step;
                     ch_next = ch_step;
                     dh_next = {dh_reg[7:4], head_step};
                     state_next = dv_pkg::DV_START;
                  end
               end
            end
         end
         dv_pkg::DV_DRAIN: begin
            // Status waits until the host has taken the last word
            if (!word_valid_reg) begin
               state_next = dv_pkg::DV_POST;
            end
         end
         dv_pkg::DV_POST: begin
            bsy_next = 1'b0;
            drq_next = 1'b0;
            corr_next = corr_acc_reg;
            state_next = dv_pkg::DV_IRQ;
         end
         dv_pkg::DV_IRQ: begin
            intrq_next = 1'b1;
            state_next = dv_pkg::DV_IDLE;
         end
         default: state_next = dv_pkg::DV_IDLE;
      endcase
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= dv_pkg::DV_IDLE;
         mode_reg <= dv_pkg::DV_DMA_MW2;
         feat_reg <= `DV_BYTE_ZERO;
         fault_reg <= `DV_BYTE_ZERO;
         sc_reg <= `DV_BYTE_ZERO;
         sn_reg <= `DV_BYTE_ZERO;
         cl_reg <= `DV_BYTE_ZERO;
         ch_reg <= `DV_BYTE_ZERO;
         dh_reg <= `DV_BYTE_ZERO;
         rdata_reg <= `DV_BYTE_ZERO;
         bsy_reg <= 1'b0;
         drq_reg <= 1'b0;
         corr_reg <= 1'b0;
         errb_reg <= 1'b0;
         corr_acc_reg <= 1'b0;
         intrq_reg <= 1'b0;
         start_reg <= 1'b0;
         verify_reg <= 1'b0;
         retry_reg <= 1'b0;
         left_reg <= 9'h000;
         word_valid_reg <= 1'b0;
         word_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         feat_reg <= feat_next;
         fault_reg <= fault_next;
         sc_reg <= sc_next;
         sn_reg <= sn_next;
         cl_reg <= cl_next;
         ch_reg <= ch_next;
         dh_reg <= dh_next;
         rdata_reg <= rdata_next;
         bsy_reg <= bsy_next;
         drq_reg <= drq_next;
         corr_reg <= corr_next;
         errb_reg <= errb_next;
         corr_acc_reg <= corr_acc_next;
         intrq_reg <= intrq_next;
         start_reg <= start_next;
         verify_reg <= verify_next;
         retry_reg <= retry_next;
         left_reg <= left_next;
         word_valid_reg <= word_valid_next;
         word_reg <= word_next;
      end
   end

   assign take = dmarq_o && dmack_i;
   assign load = med_valid_i && med_ready_o;
   // Verify never accepts media words, so nothing reaches the host
   assign med_ready_o = state_reg == dv_pkg::DV_XFER && !verify_reg &&
                        (!word_valid_reg || take);
   assign dmarq_o = word_valid_reg;
   assign dma_data_o = word_reg;
   assign dma_mode_o = mode_reg;
   assign host_rdata_o = rdata_reg;
   assign intrq_o = intrq_reg;
   assign med_start_o = start_reg;
   assign med_verify_o = verify_reg;
   assign med_retry_o = retry_reg;
   assign med_lba_mode_o = dh_reg[`DV_DH_LBA];
   assign med_addr_o = {dh_reg[3:0], ch_reg, cl_reg, sn_reg};

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n);

   property p_read_decode;
      state_reg == dv_pkg::DV_IDLE && accept && kind == dv_pkg::DV_K_READ
         |=> state_reg == dv_pkg::DV_START && bsy_reg && !verify_reg
             && retry_reg == !$past(host_wdata_i[0]);
   endproperty
   a_read_decode: assert property (p_read_decode) else $error("read not decoded");

   property p_req_in_read;
      dmarq_o |-> !verify_reg && state_reg != dv_pkg::DV_IDLE;
   endproperty
   a_req_in_read: assert property (p_req_in_read) else $error("stray dma request");

   property p_irq_once;
      $rose(intrq_o) |-> $past(state_reg) == dv_pkg::DV_IRQ ##1 !$rose(intrq_o) [*4];
   endproperty
   a_irq_once: assert property (p_irq_once) else $error("extra status post");

   property p_halt;
      state_reg == dv_pkg::DV_XFER && med_done_i && med_err_i
         |=> (!med_start_o && !med_ready_o) [*3];
   endproperty
   a_halt: assert property (p_halt) else $error("sector after error");

   property p_err_irq;
      state_reg == dv_pkg::DV_POST && errb_reg |-> ##2 intrq_o && errb_reg;
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("error not posted");

   property p_left_count;
      state_reg == dv_pkg::DV_XFER && med_done_i && med_err_i
         |=> sc_reg == $past(left_reg[7:0]) && fault_reg[`DV_ER_UNC];
   endproperty
   a_left_count: assert property (p_left_count) else $error("bad remaining count");

   property p_setf_mode;
      state_reg == dv_pkg::DV_IDLE && accept && kind == dv_pkg::DV_K_SETF &&
      feat_reg == `DV_FEAT_XFER_MODE && sc_reg == `DV_MODE_UDMA2
         |=> dma_mode_o == dv_pkg::DV_DMA_UDMA2 ##2 intrq_o && !errb_reg;
   endproperty
   a_setf_mode: assert property (p_setf_mode) else $error("mode not adopted");

   property p_bsy_first;
      $rose(intrq_o) |-> !bsy_reg && $past(!bsy_reg);
   endproperty
   a_bsy_first: assert property (p_bsy_first) else $error("irq before busy drop");

   property p_corr_before_irq;
      $rose(intrq_o) |-> corr_reg == corr_acc_reg && $past(corr_reg) == corr_acc_reg;
   endproperty
   a_corr_before_irq: assert property (p_corr_before_irq) else $error("late corr");

   property p_busy_hold;
      state_reg inside {dv_pkg::DV_START, dv_pkg::DV_XFER, dv_pkg::DV_DRAIN} |-> bsy_reg;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

   c_read_done: cover property (take ##[1:600] state_reg == dv_pkg::DV_IRQ && !errb_reg);
   c_verify_err: cover property (verify_reg && med_done_i && med_err_i);
   c_corr: cover property ($rose(intrq_o) && corr_reg);
   c_setf: cover property (accept && kind == dv_pkg::DV_K_SETF);
endmodule

// ---- design/dv_defs.svh ----
// Constants for the disk DMA read and read-verify command engine
`ifndef DV_DEFS_SVH
`define DV_DEFS_SVH

// -----------------------------------------------------------------
// Task-file offsets
// -----------------------------------------------------------------
`define DV_OFF_FEAT 10'h1F1
`define DV_OFF_SC 10'h1F2
`define DV_OFF_SN 10'h1F3
`define DV_OFF_CL 10'h1F4
`define DV_OFF_CH 10'h1F5
`define DV_OFF_DH 10'h1F6
`define DV_OFF_CMD 10'h1F7

// -----------------------------------------------------------------
// Command, feature and count codes
// -----------------------------------------------------------------
`define DV_CMD_RDMA 8'hC8
`define DV_CMD_RDMA_NR 8'hC9
`define DV_CMD_VERIFY 8'h40
`define DV_CMD_VERIFY_NR 8'h41
`define DV_CMD_SETF 8'hEF
`define DV_FEAT_XFER_MODE 8'h03
`define DV_MODE_SW2 8'h12
`define DV_MODE_MW2 8'h22
`define DV_MODE_UDMA2 8'h42

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define DV_ST_BSY 7
`define DV_ST_DRDY 6
`define DV_ST_DSC 4
`define DV_ST_DRQ 3
`define DV_ST_CORR 2
`define DV_ST_ERR 0
`define DV_ER_UNC 6
`define DV_ER_ABRT 2
`define DV_DH_LBA 6
`define DV_DH_DRV 4
`define DV_CMD_NORETRY 0
`define DV_SC_FULL 9'h100
`define DV_BYTE_ZERO 8'h00

`endif

// ---- design/dv_pkg.sv ----
// Types shared by the command engine
package dv_pkg;
   typedef enum logic [2:0] {
      DV_IDLE, DV_START, DV_XFER, DV_DRAIN, DV_POST, DV_IRQ
   } dv_state_t;
   typedef enum logic [1:0] {
      DV_DMA_SW2, DV_DMA_MW2, DV_DMA_UDMA2
   } dv_dma_mode_t;
   typedef enum logic [1:0] {
      DV_K_READ, DV_K_VERIFY, DV_K_SETF, DV_K_BAD
   } dv_kind_t;
endpackage

// ---- design/dv_rst_sync.sv ----
// Reset release synchroniser
module dv_rst_sync (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   output logic rst_n_o
);
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= 1'b1;
         sync_reg <= meta_reg;
      end
   end

   assign rst_n_o = sync_reg;
endmodule

// ---- testbench/disk_dma_read_and_verify_cmds_tb.sv ----
// Self-checking bench for the command engine against a media stand-in
`include "dv_defs.svh"
module disk_dma_read_and_verify_cmds_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = 4;
   logic clk_sys_i = 0, rst_n_i = 0, host_wr_i = 0, host_rd_i = 0, dmack_i = 0;
   logic [9:0] host_addr_i = 10'h000;
   logic [7:0] host_wdata_i = 8'h00, host_rdata_o;
   logic [15:0] err_at = 16'hFFFF, corr_at = 16'hFFFF, dma_data_o, med_data_i;
   logic intrq_o, dmarq_o, med_start_o, med_verify_o, med_retry_o, med_lba_mode_o;
   logic med_valid_i, med_ready_o, med_done_i, med_err_i, med_corr_i;
   logic [2:0] kind_seen;
   logic [27:0] med_addr_o;
   dv_pkg::dv_dma_mode_t dma_mode_o;
   int n_mismatch = 0, cmp_count = 0, base = 0;
   logic [15:0] got[$];
   logic [27:0] starts[$];
   always #5 clk_sys_i = ~clk_sys_i;
   dv_cmd_engine #(.WORDS_PER_SECTOR(W)) dv_cmd_engine_i (.clk_sys_i, .rst_n_i, .host_addr_i,
      .host_wr_i, .host_rd_i, .host_wdata_i, .host_rdata_o, .intrq_o, .dmarq_o, .dmack_i,
      .dma_data_o, .dma_mode_o, .med_start_o, .med_verify_o, .med_retry_o, .med_lba_mode_o,
      .med_addr_o, .med_data_i, .med_valid_i, .med_ready_o, .med_done_i, .med_err_i,
      .med_corr_i);
   dv_media_model #(.W(W)) dv_media_model_i (.clk_i(clk_sys_i), .rst_n_i(rst_n_i),
      .start_i(med_start_o), .verify_i(med_verify_o), .ready_i(med_ready_o),
      .err_at_i(err_at), .corr_at_i(corr_at), .data_o(med_data_i), .valid_o(med_valid_i),
      .done_o(med_done_i), .err_o(med_err_i), .corr_o(med_corr_i));
   // -----------------------------------------------------------------
   // Host side: stalling DMA acknowledge and transfer capture
   // -----------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      dmack_i <= 1'($urandom % 2);
      if (dmarq_o && dmack_i) got.push_back(dma_data_o);
      if (med_start_o) begin
         starts.push_back(med_addr_o);
         kind_seen <= {med_retry_o, med_lba_mode_o, med_verify_o};
      end
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wr(logic [9:0] a, logic [7:0] d);
      @(posedge clk_sys_i);
      host_addr_i <= a;
      host_wdata_i <= d;
      host_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      host_wr_i <= 1'b0;
   endtask
   task automatic rd(logic [9:0] a, output logic [7:0] v);
      @(posedge clk_sys_i);
      host_addr_i <= a;
      host_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      host_rd_i <= 1'b0;
      #1 v = host_rdata_o;
   endtask
   task automatic wait_irq();
      repeat (20000) if (intrq_o !== 1'b1) @(posedge clk_sys_i) #1;
      chk("irq", intrq_o, 1'b1);
   endtask
   // Next sector: block address +1, or sector 1..63, head 0..15, then cylinder
   function automatic logic [27:0] step(logic lba, logic [27:0] a);
      if (lba) return a + 28'h0000001;
      if (a[7:0] < 8'h3F) return a + 28'h0000001;
      a[7:0] = 8'h01;
      if (a[27:24] < 4'hF) return a + 28'h1000000;
      a[27:24] = 4'h0;
      return a + 28'h0000100;
   endfunction
   task automatic setf(logic [7:0] c, dv_pkg::dv_dma_mode_t m, logic ok);
      logic [7:0] v;
      wr(`DV_OFF_FEAT, `DV_FEAT_XFER_MODE);
      wr(`DV_OFF_SC, c);
      wr(`DV_OFF_CMD, `DV_CMD_SETF);
      wait_irq();
      rd(`DV_OFF_CMD, v);
      chk("setf_err", v[0], !ok);
      chk("mode", dma_mode_o, m);
   endtask
   // ea/ca: index of the failing/corrected sector, at or beyond the count for none
   task automatic run(logic [7:0] cmd, logic lba, logic [27:0] a, logic [7:0] sc, int ea,
                      int ca);
      int n, proc;
      logic [27:0] e;
      logic [7:0] v;
      logic bad, vfy;
      n = (sc == 8'h00) ? 256 : sc;
      bad = ea < n;
      proc = bad ? ea + 1 : n;
      vfy = cmd[7:1] == 7'h20;
      err_at <= 16'(base + ea);
      corr_at <= 16'(base + ca);
      got.delete();
      starts.delete();
      e = a;
      repeat (bad ? ea : n - 1) e = step(lba, e);
      wr(`DV_OFF_SC, sc);
      wr(`DV_OFF_SN, a[7:0]);
      wr(`DV_OFF_CL, a[15:8]);
      wr(`DV_OFF_CH, a[23:16]);
      wr(`DV_OFF_DH, {1'b1, lba, 1'b1, 1'b0, a[27:24]});
      wr(`DV_OFF_CMD, cmd);
      rd(`DV_OFF_CMD, v);
      chk("busy", v[7], 1'b1);
      wr(`DV_OFF_SC, 8'hFF);
      wait_irq();
      rd(`DV_OFF_CMD, v);
      chk("status", {v[7], v[2], v[0]}, {1'b0, ca < proc, bad});
      chk("irq_clr", intrq_o, 1'b0);
      rd(`DV_OFF_SC, v);
      chk("count", v, bad ? 8'(n - ea) : 8'h00);
      rd(`DV_OFF_FEAT, v);
      chk("fault", v, bad ? 8'h40 : 8'h00);
      rd(`DV_OFF_SN, v);
      chk("sn", v, e[7:0]);
      rd(`DV_OFF_CL, v);
      chk("cl", v, e[15:8]);
      rd(`DV_OFF_CH, v);
      chk("ch", v, e[23:16]);
      rd(`DV_OFF_DH, v);
      chk("dh", v & 8'h5F, {1'b0, lba, 2'b00, e[27:24]});
      chk("start", starts[0], a);
      chk("sectors", starts.size(), proc);
      chk("retry", kind_seen[2], !cmd[0]);
      chk("lba_kind", kind_seen[1], lba);
      chk("verify_kind", kind_seen[0], vfy);
      if (vfy) chk("no_data", got.size(), 0);
      else chk("words", got.size() >= (proc - bad) * W && got.size() <= proc * W, 1);
      foreach (got[i]) chk("word", got[i], {8'(base + i / W), 8'(i % W)});
      base += proc;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      final_report();
   end
   initial begin
      void'($urandom(72566));
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      chk("mode_rst", dma_mode_o, dv_pkg::DV_DMA_MW2);
      setf(`DV_MODE_SW2, dv_pkg::DV_DMA_SW2, 1'b1);
      setf(8'h55, dv_pkg::DV_DMA_SW2, 1'b0);
      setf(`DV_MODE_UDMA2, dv_pkg::DV_DMA_UDMA2, 1'b1);
      setf(`DV_MODE_MW2, dv_pkg::DV_DMA_MW2, 1'b1);
      run(`DV_CMD_RDMA, 1'b0, {4'h3, 16'h0102, 8'h3E}, 8'h03, 9, 1);
      run(`DV_CMD_RDMA_NR, 1'b1, 28'($urandom), 8'h04, 1, 9);
      run(`DV_CMD_VERIFY, 1'b0, {4'hF, 16'h00FF, 8'h3F}, 8'h02, 9, 0);
      run(`DV_CMD_VERIFY_NR, 1'b1, 28'hFFFFFFE, 8'h03, 2, 1);
      run(`DV_CMD_VERIFY, 1'b0, {4'h0, 16'($urandom), 8'h01}, 8'h00, 255, 300);
      final_report();
   end
endmodule

// ---- testbench/dv_media_model.sv ----
// Media engine stand-in that answers each sector start with W words (none for verify) and an end pulse
module dv_media_model #(
   parameter int W = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic verify_i,
   input wire logic ready_i,
   input wire logic [15:0] err_at_i,
   input wire logic [15:0] corr_at_i,
   output logic [15:0] data_o,
   output logic valid_o,
   output logic done_o,
   output logic err_o,
   output logic corr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int left;
   logic run;
   logic [15:0] sec;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run <= 1'b0;
         left <= 0;
         sec <= 16'h0000;
         data_o <= 16'h0000;
         {valid_o, done_o, err_o, corr_o} <= 4'h0;
      end else begin
         done_o <= 1'b0;
         err_o <= 1'b0;
         corr_o <= 1'b0;
         // Idle bus toggles so a stale word never passes for a fresh one
         if (!valid_o) data_o <= ~data_o;
         if (start_i) begin
            run <= 1'b1;
            left <= verify_i ? 0 : W;
            valid_o <= !verify_i;
            data_o <= {sec[7:0], 8'h00};
         end else if (valid_o && ready_i) begin
            left <= left - 1;
            valid_o <= left > 1;
            data_o <= (left > 1) ? data_o + 16'h0001 : ~data_o;
         end else if (run && !valid_o && ($urandom % 3 == 0)) begin
            // Random gap before the end pulse gives prompt and slow sectors
            run <= 1'b0;
            done_o <= 1'b1;
            err_o <= sec == err_at_i;
            corr_o <= sec == corr_at_i;
            sec <= sec + 16'h0001;
         end
      end
   end
endmodule
